// [sdimlc_defines.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef SDIMLC_DEFINES_SVH
`define SDIMLC_DEFINES_SVH
`define SDIMLC_ADDR_MODE 12'h001
`define SDIMLC_ADDR_FEAT 12'h002
`define SDIMLC_ADDR_STATUS 12'h003
`define SDIMLC_ADDR_DRIVE 12'h06D
`define SDIMLC_DRIVE_RST 16'h0000
`define SDIMLC_FEAT_RST 16'hFFFF
`define SDIMLC_MODE_RST 5'h00
`define SDIMLC_MODE_OVR_BIT 4
`define SDIMLC_CODE_VIDEO 2'h0
`define SDIMLC_CODE_ASI 2'h1
`define SDIMLC_CODE_PASS 2'h2
`define SDIMLC_CODE_STANDBY 2'h3
`define SDIMLC_CMD_RD_BIT 15
`define SDIMLC_CMD_AI_BIT 12
`define SDIMLC_WORD_LAST 4'hF
`define SDIMLC_CLK_MHZ 25
`define SDIMLC_LOCK_MIN_US 100
`define SDIMLC_LOCK_MAX_AUTO_US 600
`define SDIMLC_LOCK_MAX_MAN_US 350
`define SDIMLC_LOCK_MIN_CYC (`SDIMLC_LOCK_MIN_US * `SDIMLC_CLK_MHZ)
`define SDIMLC_LOCK_MAX_AUTO_CYC (`SDIMLC_LOCK_MAX_AUTO_US * `SDIMLC_CLK_MHZ)
`define SDIMLC_LOCK_MAX_MAN_CYC (`SDIMLC_LOCK_MAX_MAN_US * `SDIMLC_CLK_MHZ)
`endif

// [sdimlc_pkg.sv]
// Types shared by the mode and loop output control block
package sdimlc_pkg;
  typedef enum logic [3:0] {
    MODE_VIDEO = 4'h1, MODE_ASI = 4'h2, MODE_PASS = 4'h4, MODE_STANDBY = 4'h8
  } sdimlc_mode_type;
  typedef enum logic [3:0] {
    LOOP_OFF = 4'h1, LOOP_MUTE = 4'h2, LOOP_RETIME = 4'h4, LOOP_BUFFER = 4'h8
  } sdimlc_loop_type;
  typedef struct packed {
    logic [9:0] data;
    logic asi_dec;
    logic raw;
  } sdimlc_word_type;
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [15:0] wdata;
  } sdimlc_hreq_type;
  typedef struct packed {
    sdimlc_word_type e0;
    sdimlc_word_type e1;
    logic [1:0] cnt;
    logic in_ready;
    logic out_valid;
  } sdimlc_buf_type;
  typedef struct packed {
    logic sclk_p;
    logic [3:0] cnt;
    logic [15:0] sh_in;
    logic [15:0] sh_out;
    logic cmd_done;
    logic rd;
    logic ai;
    logic pend;
    logic sdout;
    sdimlc_hreq_type req;
  } sdimlc_host_type;
endpackage

// [sdimlc_buf2.sv]
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sdimlc_buf2 (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Freeze both sides
  input wire logic i_hold,
  // Filling side
  input var sdimlc_pkg::sdimlc_word_type i_data,
  input wire logic i_valid,
  output logic o_ready,
  // Draining side
  output var sdimlc_pkg::sdimlc_word_type o_data,
  output logic o_valid,
  input wire logic i_ready
);
  import sdimlc_pkg::*;
  sdimlc_buf_type q, n;
  logic [1:0] c;
  always_comb begin
    n = q;
    c = q.cnt;
    if (!i_hold && q.out_valid && i_ready) begin
      n.e0 = q.e1;
      c = c - 2'h1;
    end
    if (!i_hold && q.in_ready && i_valid) begin
      if (c == 2'h0) begin
        n.e0 = i_data;
      end else begin
        n.e1 = i_data;
      end
      c = c + 2'h1;
    end
    n.cnt = c;
    // Flags from the next count keep both handshakes flop-driven
    n.in_ready = !i_hold && (c != 2'h2);
    n.out_valid = !i_hold && (c != 2'h0);
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign o_data = q.e0;
  assign o_valid = q.out_valid;
  assign o_ready = q.in_ready;
endmodule
`default_nettype wire

// [sdimlc_host_port.sv]
// Host serial port slave: command word then data words
`timescale 1ns/10ps
`default_nettype none
`include "sdimlc_defines.svh"
module sdimlc_host_port (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Port pins
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_sdin,
  output logic o_sdout,
  // Register side
  output var sdimlc_pkg::sdimlc_hreq_type o_req,
  input wire logic [15:0] i_rdata
);
  import sdimlc_pkg::*;
  sdimlc_host_type q, n;
  logic [15:0] word;
  logic rise;
  logic fall;
  always_comb begin
    n = q;
    word = {q.sh_in[14:0], i_sdin};
    rise = i_sclk && !q.sclk_p;
    fall = !i_sclk && q.sclk_p;
    n.sclk_p = i_sclk;
    n.req.wr = 1'b0;
    if (q.req.wr && q.ai) begin
      n.req.addr = q.req.addr + 12'h001;
    end
    if (i_cs_n) begin
      n.cnt = 4'h0;
      n.cmd_done = 1'b0;
      n.pend = 1'b0;
    end else begin
      // One cycle fetch sits well inside the host's gap
      if (q.pend) begin
        n.pend = 1'b0;
        n.sh_out = i_rdata;
        n.sdout = i_rdata[15];
      end else if (fall && q.cmd_done && q.rd && q.cnt != 4'h0) begin
        // A fall before the first data rise would drop the top bit
        n.sh_out = {q.sh_out[14:0], 1'b0};
        n.sdout = q.sh_out[14];
      end
      if (rise) begin
        n.sh_in = word;
        n.cnt = q.cnt + 4'h1;
        if (q.cnt == `SDIMLC_WORD_LAST) begin
          if (!q.cmd_done) begin
            n.cmd_done = 1'b1;
            n.rd = word[`SDIMLC_CMD_RD_BIT];
            n.ai = word[`SDIMLC_CMD_AI_BIT];
            n.req.addr = word[11:0];
            n.pend = word[`SDIMLC_CMD_RD_BIT];
          end else if (!q.rd) begin
            n.req.wr = 1'b1;
            n.req.wdata = word;
          end else if (q.ai) begin
            n.req.addr = q.req.addr + 12'h001;
            n.pend = 1'b1;
          end
        end
      end
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign o_sdout = q.sdout;
  assign o_req = q.req;
endmodule
`default_nettype wire

// [sdimlc_top.sv]
// Operating mode, lock timing and loop-through output control
`timescale 1ns/10ps
`default_nettype none
`include "sdimlc_defines.svh"
module sdimlc_top #(
  parameter int unsigned LOCK_MAX_AUTO_CYC = `SDIMLC_LOCK_MAX_AUTO_CYC,
  parameter int unsigned LOCK_MAX_MAN_CYC = `SDIMLC_LOCK_MAX_MAN_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Control pins
  input wire logic i_loop_output_enable_pin,
  input wire logic i_reclock_select_pin,
  input wire logic i_standby_pin,
  input wire logic i_auto_mode_pin,
  // Mode indication pins, two-way
  input wire logic i_video_processing_indicator,
  output logic o_video_processing_indicator,
  output logic o_video_processing_indicator_oe,
  input wire logic i_asi_indicator,
  output logic o_asi_indicator,
  output logic o_asi_indicator_oe,
  // Serial stream and reclocker
  input wire logic i_serial_bit,
  input wire logic i_retimed_bit,
  input wire logic i_pll_raw_lock,
  output logic o_reclocker_en,
  output logic o_locked,
  // Loop-through output toward the cable driver
  output logic o_loop_through_output_p,
  output logic o_loop_through_output_n,
  // Parallel words in
  input wire logic [9:0] i_word,
  input wire logic i_word_valid,
  output logic o_word_ready,
  // Parallel words out
  output var sdimlc_pkg::sdimlc_word_type o_pdata,
  output logic o_pdata_valid,
  input wire logic i_pdata_ready,
  // Processing controls
  output logic [15:0] o_video_feat_en,
  output logic o_asi_decode_en,
  output logic o_pass_only,
  // Output pin drive
  output logic o_out_pins_oe,
  output logic [15:0] o_drive_strength,
  // Host serial port
  input wire logic i_host_serial_port_cs_n,
  input wire logic i_host_serial_port_sclk,
  input wire logic i_host_serial_port_sdin,
  output logic o_host_serial_port_sdout,
  output logic o_host_serial_port_sdout_oe
);
  import sdimlc_pkg::*;

  typedef struct packed {
    logic strap_done;
    logic strap_vpi;
    logic strap_asi;
    logic [4:0] modecfg;
    logic [15:0] feat;
    logic [15:0] drive;
    sdimlc_mode_type mode;
    logic locked;
    logic [11:0] qual_cnt;
    logic [13:0] search_cnt;
    sdimlc_loop_type loop_sel;
    logic loop_p;
    logic loop_n;
    logic pins_oe;
    logic vpi_out;
    logic asi_out;
    logic reclk_en;
    logic [15:0] feat_out;
    logic asi_dec_en;
    logic pass_only;
  } sdimlc_state_type;

  sdimlc_state_type q, n;
  sdimlc_hreq_type hreq;
  sdimlc_word_type word_in;
  sdimlc_mode_type mode_w;
  sdimlc_mode_type strap_mode;
  sdimlc_mode_type cfg_mode;
  sdimlc_loop_type sel_w;
  logic [15:0] rdata;
  logic [13:0] max_w;
  logic cfg_ok;
  logic hp_sdout;

  // Counts as 14 bits; a shortened max must stay above the min
  localparam logic [13:0] LOCK_MIN_LAST = 14'(`SDIMLC_LOCK_MIN_CYC - 1);
  localparam logic [13:0] LOCK_AUTO_LAST = 14'(LOCK_MAX_AUTO_CYC - 1);
  localparam logic [13:0] LOCK_MAN_LAST = 14'(LOCK_MAX_MAN_CYC - 1);

  sdimlc_host_port u_host (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_cs_n(i_host_serial_port_cs_n),
    .i_sclk(i_host_serial_port_sclk),
    .i_sdin(i_host_serial_port_sdin),
    .o_sdout(hp_sdout),
    .o_req(hreq),
    .i_rdata(rdata)
  );

  // Words are tagged with the decode path they take downstream
  always_comb begin
    word_in.data = i_word;
    word_in.asi_dec = (q.mode == MODE_ASI);
    word_in.raw = (q.mode == MODE_PASS);
  end

  // Standby freezes the parallel side so the output stays static
  sdimlc_buf2 u_buf (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_hold(q.mode == MODE_STANDBY),
    .i_data(word_in),
    .i_valid(i_word_valid),
    .o_ready(o_word_ready),
    .o_data(o_pdata),
    .o_valid(o_pdata_valid),
    .i_ready(i_pdata_ready)
  );

  // Mode register stays writable in standby, else it could never be left
  always_comb begin
    cfg_ok = (q.mode != MODE_STANDBY);
    rdata = 16'h0000;
    case (hreq.addr)
      `SDIMLC_ADDR_MODE: begin
        rdata = {11'h000, q.modecfg};
      end
      `SDIMLC_ADDR_STATUS: begin
        rdata = {4'h0, q.reclk_en, q.strap_asi, q.strap_vpi,
                 q.loop_sel, q.mode, q.locked};
      end
      `SDIMLC_ADDR_FEAT: begin
        if (cfg_ok) begin
          rdata = q.feat;
        end
      end
      `SDIMLC_ADDR_DRIVE: begin
        if (cfg_ok) begin
          rdata = q.drive;
        end
      end
      default: begin
        rdata = 16'h0000;
      end
    endcase
  end

  always_comb begin
    n = q;
    strap_mode = MODE_PASS;
    cfg_mode = MODE_VIDEO;
    mode_w = MODE_VIDEO;
    sel_w = LOOP_OFF;
    max_w = i_auto_mode_pin ? LOCK_AUTO_LAST : LOCK_MAN_LAST;

    // Strap levels are caught once, while the two-way pins still float
    if (!q.strap_done) begin
      n.strap_done = 1'b1;
      n.strap_vpi = i_video_processing_indicator;
      n.strap_asi = i_asi_indicator;
    end
    if (q.strap_vpi) begin
      strap_mode = MODE_VIDEO;
    end else if (q.strap_asi) begin
      strap_mode = MODE_ASI;
    end

    unique case (q.modecfg[1:0])
      `SDIMLC_CODE_VIDEO: cfg_mode = MODE_VIDEO;
      `SDIMLC_CODE_ASI: cfg_mode = MODE_ASI;
      `SDIMLC_CODE_PASS: cfg_mode = MODE_PASS;
      `SDIMLC_CODE_STANDBY: cfg_mode = MODE_STANDBY;
    endcase

    // Pin standby overrides, then host selection, then straps
    if (i_standby_pin) begin
      mode_w = MODE_STANDBY;
    end else if (q.modecfg[`SDIMLC_MODE_OVR_BIT]) begin
      mode_w = cfg_mode;
    end else begin
      mode_w = strap_mode;
    end
    n.mode = mode_w;

    // Entry defaults first, so a write in the same cycle still lands
    if (mode_w == MODE_VIDEO && q.mode != MODE_VIDEO) begin
      n.feat = `SDIMLC_FEAT_RST;
    end
    if (hreq.wr) begin
      case (hreq.addr)
        `SDIMLC_ADDR_MODE: begin
          n.modecfg = hreq.wdata[4:0];
        end
        `SDIMLC_ADDR_FEAT: begin
          if (cfg_ok) begin
            n.feat = hreq.wdata;
          end
        end
        `SDIMLC_ADDR_DRIVE: begin
          if (cfg_ok) begin
            n.drive = hreq.wdata;
          end
        end
        default: begin
        end
      endcase
    end

    // Lock: qualified no sooner than the min; a flickering raw lock
    // cannot push it past the max
    if (mode_w == MODE_STANDBY) begin
      n.locked = q.locked;
    end else if (q.locked) begin
      if (!i_pll_raw_lock) begin
        n.locked = 1'b0;
        n.qual_cnt = 12'h000;
        n.search_cnt = 14'h0000;
      end
    end else begin
      if (q.search_cnt < max_w) begin
        n.search_cnt = q.search_cnt + 14'h0001;
      end
      if (!i_pll_raw_lock) begin
        n.qual_cnt = 12'h000;
      end else if (q.qual_cnt != LOCK_MIN_LAST[11:0]) begin
        n.qual_cnt = q.qual_cnt + 12'h001;
      end
      if (i_pll_raw_lock && q.search_cnt >= LOCK_MIN_LAST &&
          (q.qual_cnt == LOCK_MIN_LAST[11:0] || q.search_cnt >= max_w)) begin
        n.locked = 1'b1;
      end
    end

    // Priority: disabled or standby pin, then mute, then retimed or buffered
    if (!i_loop_output_enable_pin) begin
      sel_w = LOOP_OFF;
    end else if (i_standby_pin) begin
      sel_w = LOOP_OFF;
    end else if (i_reclock_select_pin && !q.locked) begin
      sel_w = LOOP_MUTE;
    end else if (i_reclock_select_pin) begin
      sel_w = LOOP_RETIME;
    end else begin
      sel_w = LOOP_BUFFER;
    end
    n.loop_sel = sel_w;
    unique case (sel_w)
      LOOP_OFF: begin
        n.loop_p = 1'b1;
        n.loop_n = 1'b1;
      end
      LOOP_MUTE: begin
        n.loop_p = 1'b0;
        n.loop_n = 1'b1;
      end
      LOOP_RETIME: begin
        n.loop_p = i_retimed_bit;
        n.loop_n = !i_retimed_bit;
      end
      LOOP_BUFFER: begin
        n.loop_p = i_serial_bit;
        n.loop_n = !i_serial_bit;
      end
    endcase

    // Pins leave high impedance from the first edge after reset
    n.pins_oe = 1'b1;
    n.vpi_out = (mode_w == MODE_VIDEO);
    n.asi_out = (mode_w == MODE_ASI);
    n.reclk_en = (mode_w != MODE_STANDBY);
    n.feat_out = (mode_w == MODE_VIDEO) ? n.feat : 16'h0000;
    n.asi_dec_en = (mode_w == MODE_ASI);
    n.pass_only = (mode_w == MODE_PASS);
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
      q.modecfg <= `SDIMLC_MODE_RST;
      q.feat <= `SDIMLC_FEAT_RST;
      q.drive <= `SDIMLC_DRIVE_RST;
      q.mode <= MODE_PASS;
      q.loop_sel <= LOOP_OFF;
      q.loop_p <= 1'b1;
      q.loop_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign o_video_processing_indicator = q.vpi_out;
  assign o_video_processing_indicator_oe = q.pins_oe;
  assign o_asi_indicator = q.asi_out;
  assign o_asi_indicator_oe = q.pins_oe;
  assign o_reclocker_en = q.reclk_en;
  assign o_locked = q.locked;
  assign o_loop_through_output_p = q.loop_p;
  assign o_loop_through_output_n = q.loop_n;
  assign o_video_feat_en = q.feat_out;
  assign o_asi_decode_en = q.asi_dec_en;
  assign o_pass_only = q.pass_only;
  assign o_out_pins_oe = q.pins_oe;
  assign o_drive_strength = q.drive;
  assign o_host_serial_port_sdout = hp_sdout;
  assign o_host_serial_port_sdout_oe = q.pins_oe;
endmodule
`default_nettype wire

// [sdimlc_sva.sv]
// Port assertions for the mode and loop output control block
`timescale 1ns/10ps
`default_nettype none
module sdimlc_sva (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Pins
  input wire logic i_loop_output_enable_pin,
  input wire logic i_reclock_select_pin,
  input wire logic i_standby_pin,
  input wire logic i_serial_bit,
  input wire logic i_retimed_bit,
  input wire logic i_pll_raw_lock,
  // Outputs
  input wire logic o_loop_through_output_p,
  input wire logic o_loop_through_output_n,
  input wire logic o_locked,
  input wire logic o_reclocker_en,
  input wire logic o_out_pins_oe,
  input wire logic o_asi_indicator_oe,
  input wire logic o_pass_only,
  input wire logic o_asi_decode_en,
  input wire logic [15:0] o_video_feat_en
);
  logic [11:0] unl_q;
  logic [11:0] held_q;
  logic rst_q;
  wire logic on_w;
  assign on_w = i_loop_output_enable_pin && !i_standby_pin;
  default clocking @(posedge i_clk_sys); endclocking
  // Reset drops on a clock edge; attempts from that edge still see reset-time outputs
  default disable iff (i_rst || rst_q);
  // Saturating, so a long stall cannot wrap into a false pass
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rst_q <= 1'b1;
      unl_q <= 12'h000;
      held_q <= 12'h000;
    end else begin
      rst_q <= 1'b0;
      unl_q <= o_locked ? 12'h000 : unl_q + {11'h000, unl_q != 12'hFFF};
      held_q <= (o_locked || !i_pll_raw_lock || i_standby_pin) ? 12'h000 : held_q + {11'h000, held_q != 12'hFFF};
    end
  end
  AST_OFF: assert property (!i_loop_output_enable_pin |=> o_loop_through_output_p && o_loop_through_output_n)
    else $error("loop pair not high while disabled");
  AST_STBY_OFF: assert property (i_standby_pin |=> o_loop_through_output_p && o_loop_through_output_n)
    else $error("loop pair not high in standby");
  AST_MUTE: assert property (on_w && i_reclock_select_pin && !o_locked ##1 !o_locked |->
    !o_loop_through_output_p && o_loop_through_output_n) else $error("loop output not muted");
  AST_RETIME: assert property (on_w && i_reclock_select_pin && o_locked ##1 o_locked |->
    o_loop_through_output_p == $past(i_retimed_bit) && o_loop_through_output_n != o_loop_through_output_p)
    else $error("retimed stream not on loop output");
  AST_BUFFER: assert property (on_w && !i_reclock_select_pin |=> o_loop_through_output_p == $past(i_serial_bit)
    && o_loop_through_output_n != o_loop_through_output_p) else $error("buffered stream not on loop output");
  AST_OE_RUN: assert property (!$past(i_rst) |-> o_out_pins_oe && o_asi_indicator_oe)
    else $error("pins not driven after reset");
  AST_OE_RESET: assert property (disable iff (1'b0) i_rst ##1 i_rst |-> !o_out_pins_oe && !o_asi_indicator_oe)
    else $error("pins driven during reset");
  AST_LOCK_MIN: assert property ($rose(o_locked) |-> unl_q >= 12'h9C4)
    else $error("lock reached too early");
  AST_LOCK_MAX: assert property (held_q <= 12'h9C4)
    else $error("lock reached too late");
  AST_LOCK_DROP: assert property (!i_pll_raw_lock && !i_standby_pin |=> !o_locked)
    else $error("lock kept without raw lock");
  AST_STBY_MODE: assert property (i_standby_pin [*3] |-> !o_reclocker_en && !o_pass_only && !o_asi_decode_en
    && o_video_feat_en == 16'h0000) else $error("processing active in standby");
  AST_PASS: assert property (o_pass_only |-> o_video_feat_en == 16'h0000 && !o_asi_decode_en)
    else $error("processing active in pass-through");
  COV_MUTE: cover property (on_w && i_reclock_select_pin && !o_locked);
  COV_RETIME: cover property (on_w && i_reclock_select_pin && o_locked);
  COV_LOCK: cover property ($rose(o_locked));
endmodule
bind sdimlc_top sdimlc_sva u_sva (.*);
`default_nettype wire

// [sdimlc_cable_model.sv]
// Cable driver model on the loop-through output
`timescale 1ns/10ps
`default_nettype none
module sdimlc_cable_model (
  // Clock
  input wire logic i_clk_sys,
  // Pair from the block
  input wire logic i_p,
  input wire logic i_n,
  // Received bit and cycles since the pair last moved
  output logic o_bit,
  output logic [7:0] o_quiet
);
  logic [1:0] last_q = 2'h3;
  logic [7:0] quiet_q = 8'h00;
  // Driver only listens; a stuck pair shows as a growing quiet count
  assign o_bit = i_p;
  assign o_quiet = quiet_q;
  always @(posedge i_clk_sys) begin
    last_q <= {i_p, i_n};
    quiet_q <= ({i_p, i_n} != last_q) ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hFF};
  end
endmodule
`default_nettype wire

// [sdimlc_tb.sv]
// Self-checking bench for the mode and loop output control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sdimlc_pkg::*;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_loop_output_enable_pin = 1'b1, i_reclock_select_pin = 1'b0;
  logic i_standby_pin = 1'b0, i_auto_mode_pin = 1'b1, i_serial_bit = 1'b0, i_retimed_bit = 1'b0;
  logic i_pll_raw_lock = 1'b1, i_word_valid = 1'b0, i_pdata_ready = 1'b0, i_host_serial_port_cs_n = 1'b1;
  logic i_host_serial_port_sclk = 1'b0, i_host_serial_port_sdin = 1'b0;
  logic [9:0] i_word = 10'h000;
  logic o_video_processing_indicator, o_video_processing_indicator_oe, o_asi_indicator, o_asi_indicator_oe;
  logic o_reclocker_en, o_locked, o_loop_through_output_p, o_loop_through_output_n, o_word_ready;
  logic o_pdata_valid, o_asi_decode_en, o_pass_only, o_out_pins_oe, o_host_serial_port_sdout;
  logic o_host_serial_port_sdout_oe, cab_bit;
  logic [15:0] o_video_feat_en, o_drive_strength;
  logic [7:0] cab_quiet;
  sdimlc_word_type o_pdata;
  wire logic i_video_processing_indicator, i_asi_indicator;
  wire logic [3:0] mode_obs;
  int errors = 0, check_count = 0;
  time t0 = 0;
  // Straps: one pin pulled up, one down, while the block is not driving
  assign i_video_processing_indicator = o_video_processing_indicator_oe ? o_video_processing_indicator : 1'b1;
  assign i_asi_indicator = o_asi_indicator_oe ? o_asi_indicator : 1'b0;
  assign mode_obs = {o_video_processing_indicator, o_asi_decode_en, o_pass_only, o_reclocker_en};
  always #20 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) {i_retimed_bit, i_serial_bit} <= {i_retimed_bit, i_serial_bit} + 2'h1;
  sdimlc_top #(.LOCK_MAX_AUTO_CYC(3000), .LOCK_MAX_MAN_CYC(2800)) DUT (.*);
  sdimlc_cable_model u_cab (.i_clk_sys(i_clk_sys), .i_p(o_loop_through_output_p), .i_n(o_loop_through_output_n),
    .o_bit(cab_bit), .o_quiet(cab_quiet));
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Each clock phase lasts two cycles so the block's edge sampler sees it
  task automatic shift16(input logic [15:0] w, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      i_host_serial_port_sdin <= w[i];
      cyc(2);
      i_host_serial_port_sclk <= 1'b1;
      cyc(2);
      r[i] = o_host_serial_port_sdout;
      i_host_serial_port_sclk <= 1'b0;
    end
  endtask
  task automatic hport(input logic rd, input logic [11:0] a, input logic [15:0] wd, output logic [15:0] rq);
    logic [15:0] cmd_r;
    i_host_serial_port_cs_n <= 1'b0;
    cyc(1);
    shift16({rd, 3'h0, a}, cmd_r);
    cyc(4);
    shift16(wd, rq);
    cyc(3);
    i_host_serial_port_cs_n <= 1'b1;
    cyc(4);
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [15:0] r;
    hport(1'b0, a, d, r);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] r;
    hport(1'b1, a, 16'h0000, r);
    chk("register read", r, exp);
  endtask
  task automatic lchk(input logic rt);
    logic b;
    repeat (4) begin
      b = rt ? i_retimed_bit : i_serial_bit;
      cyc(1);
      chk("loop bit", {o_loop_through_output_n, cab_bit}, {!b, b});
    end
  endtask
  task automatic pair(input logic [1:0] exp);
    cyc(9);
    chk("loop pair", {o_loop_through_output_p, o_loop_through_output_n, cab_quiet > 8'h05}, {exp, 1'b1});
  endtask
  task automatic waitlock;
    for (int k = 0; k < 4000 && o_locked !== 1'b1; k++) cyc(1);
    chk("lock time", ($time - t0 >= 100000) && ($time - t0 <= 120080), 1'b1);
  endtask
  initial begin
    cyc(19);
    chk("reset pins", {o_out_pins_oe, o_asi_indicator_oe, o_video_processing_indicator_oe,
      o_host_serial_port_sdout_oe, o_loop_through_output_p, o_loop_through_output_n}, 6'h03);
    cyc(1);
    i_rst <= 1'b0;
    t0 = $time;
    cyc(3);
    chk("run pins", {o_out_pins_oe, o_video_processing_indicator_oe, o_asi_indicator_oe,
      o_host_serial_port_sdout_oe}, 4'hF);
    chk("strap mode", {o_video_processing_indicator, o_asi_indicator}, 2'h2);
    chk("features", o_video_feat_en, 16'hFFFF);
    chk("drive reset", o_drive_strength, 16'h0000);
    lchk(1'b0);
    i_reclock_select_pin <= 1'b1;
    pair(2'h1);
    i_loop_output_enable_pin <= 1'b0;
    pair(2'h3);
    i_loop_output_enable_pin <= 1'b1;
    waitlock;
    cyc(2);
    lchk(1'b1);
    i_standby_pin <= 1'b1;
    pair(2'h3);
    chk("standby", {o_reclocker_en, o_word_ready, o_locked}, 3'h1);
    wr(12'h06D, 16'h1234);
    rchk(12'h06D, 16'h0000);
    i_standby_pin <= 1'b0;
    cyc(4);
    wr(12'h06D, 16'hA5C3);
    rchk(12'h06D, 16'hA5C3);
    chk("drive out", o_drive_strength, 16'hA5C3);
    rchk(12'h7FF, 16'h0000);
    wr(12'h002, 16'h00F0);
    cyc(2);
    chk("features", o_video_feat_en, 16'h00F0);
    for (int c = 1; c < 5; c++) begin
      wr(12'h001, {14'h0004, c[1:0]});
      cyc(4);
      chk("mode outputs", mode_obs, {c == 4, c == 1, c == 2, c != 3});
      if (c == 3) rchk(12'h002, 16'h0000);
    end
    chk("features", o_video_feat_en, 16'hFFFF);
    i_pll_raw_lock <= 1'b0;
    cyc(3);
    chk("lock drop", o_locked, 1'b0);
    pair(2'h1);
    i_pll_raw_lock <= 1'b1;
    t0 = $time;
    waitlock;
    i_word_valid <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      i_word <= 10'h155 + k[9:0];
      do cyc(1); while (o_word_ready !== 1'b1);
    end
    i_word_valid <= 1'b0;
    cyc(2);
    chk("buffer full", {o_word_ready, o_pdata_valid}, 2'h1);
    i_pdata_ready <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      do cyc(1); while (o_pdata_valid !== 1'b1);
      chk("word out", o_pdata.data, 10'h155 + k[9:0]);
    end
    i_pdata_ready <= 1'b0;
    cyc(2);
    chk("buffer empty", {o_word_ready, o_pdata_valid}, 2'h2);
    conclude;
  end
  initial begin
    #(40 * 20000);
    errors++;
    conclude;
  end
endmodule
`default_nettype wire
